// [hw/link_ctrl_defines.svh]
// Offsets, field positions, reset values and widths of the link control bank.
// Assumes a 32-bit word port with byte addresses on word boundaries.
`ifndef LINK_CTRL_DEFINES_SVH
`define LINK_CTRL_DEFINES_SVH

// Register byte addresses
`define OFS_CONTROL      8'h00
`define OFS_CREDIT       8'h04
`define OFS_RETRY_CFG    8'h08
`define OFS_SLIP         8'h0c
`define OFS_RETRY_TALLY  8'h10
`define OFS_FLIP_TALLY   8'h14
`define OFS_TALLY_CLEAR  8'h18
`define OFS_STATUS       8'h1c
`define OFS_RSP_LO       8'h20
`define OFS_RSP_HI       8'h24
`define OFS_IRQ_STATUS   8'h28
`define OFS_IRQ_MASK     8'h2c

// Control register bit positions
`define BIT_MEM_RESET    0
`define BIT_SLEEP_REQ    1
`define BIT_SCR_BYPASS   2
`define BIT_LIMITER_OFF  3

// Retry configuration field positions
`define POS_RX_THRESH    0
`define POS_TX_COUNT     8
`define POS_CUBE_ID      16

// Status register field positions
`define BIT_SLEEP_MODE   0
`define POS_MARKER_CNT   8

// Field widths
`define W_CREDIT         10
`define W_MARKER         5
`define W_SLIP           8
`define W_CUBE           3
`define W_IRQ            4

// Reset values
`define RST_MEM_RESET    1'h1
`define RST_SLEEP_REQ    1'h1
`define RST_SCR_BYPASS   1'h1
`define RST_LIMITER_OFF  1'h1
`define RST_CREDIT       10'h0ff
`define RST_RX_THRESH    5'h10
`define RST_TX_COUNT     5'h14
`define RST_SLIP         8'h30
`define RST_CUBE_ID      3'h0

// Interrupt bit positions
`define IRQ_RETRY        0
`define IRQ_FLIP         1
`define IRQ_THRESH       2
`define IRQ_ERR_RSP      3

`endif

// [hw/link_ctrl_pkg.sv]
// Types shared by the link control bank.
// Assumes the defines header supplies all numbers.
package link_ctrl_pkg;

	// Register port address and data
	typedef logic [7:0]  addr_t;
	typedef logic [31:0] word_t;

	// Decoded register selection
	typedef enum logic [3:0] {
		sel_none        = 4'h0,
		sel_control     = 4'h1,
		sel_credit      = 4'h2,
		sel_retry_cfg   = 4'h3,
		sel_slip        = 4'h4,
		sel_retry_tally = 4'h5,
		sel_flip_tally  = 4'h6,
		sel_tally_clear = 4'h7,
		sel_status      = 4'h8,
		sel_rsp_lo      = 4'h9,
		sel_rsp_hi      = 4'ha,
		sel_irq_status  = 4'hb,
		sel_irq_mask    = 4'hc
	} reg_sel_t;

endpackage

// [hw/link_ctrl_regs.sv]
// Control fields and event counters of a serial memory link controller.
// Assumes every event input comes from logic on ref_clk_i and is a
// one-cycle pulse; the register port master never needs a wait.
`include "link_ctrl_defines.svh"

module link_ctrl_regs #(
	// Receive buffer tokens at build time
	parameter logic [`W_CREDIT-1:0] receive_credit_parameter = `RST_CREDIT
) (
	input  wire logic                   ref_clk_i,
	input  wire logic                   nrst_i,
	// Register port
	input  wire link_ctrl_pkg::addr_t   addr_i,
	input  wire link_ctrl_pkg::word_t   wr_data_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	output link_ctrl_pkg::word_t        rd_data_o,
	// Events from link logic
	input  wire logic                   retry_done_i,
	input  wire logic                   bit_flip_i,
	input  wire logic                   marker_rx_i,
	input  wire logic                   marker_rx_clear_i,
	input  wire logic                   rsp_rcvd_i,
	input  wire logic                   rsp_error_i,
	input  wire logic                   sleep_mode_i,
	// Control fields toward link logic
	output logic                        mem_reset_n_o,
	output logic                        sleep_req_o,
	output logic                        scramble_bypass_o,
	output logic                        limiter_off_o,
	output logic [`W_CREDIT-1:0]        receive_credit_size_o,
	output logic [`W_MARKER-1:0]        retry_marker_rx_threshold_o,
	output logic [`W_MARKER-1:0]        retry_marker_tx_count_o,
	output logic [`W_SLIP-1:0]          slip_pulse_interval_o,
	output logic [`W_CUBE-1:0]          lead_cube_identifier_o,
	output logic                        retry_action_o,
	output logic                        irq_o
);

	// Address decode, used by both write and read paths
	function automatic link_ctrl_pkg::reg_sel_t decode(
		input link_ctrl_pkg::addr_t a
	);
		case (a)
			`OFS_CONTROL:     decode = link_ctrl_pkg::sel_control;
			`OFS_CREDIT:      decode = link_ctrl_pkg::sel_credit;
			`OFS_RETRY_CFG:   decode = link_ctrl_pkg::sel_retry_cfg;
			`OFS_SLIP:        decode = link_ctrl_pkg::sel_slip;
			`OFS_RETRY_TALLY: decode = link_ctrl_pkg::sel_retry_tally;
			`OFS_FLIP_TALLY:  decode = link_ctrl_pkg::sel_flip_tally;
			`OFS_TALLY_CLEAR: decode = link_ctrl_pkg::sel_tally_clear;
			`OFS_STATUS:      decode = link_ctrl_pkg::sel_status;
			`OFS_RSP_LO:      decode = link_ctrl_pkg::sel_rsp_lo;
			`OFS_RSP_HI:      decode = link_ctrl_pkg::sel_rsp_hi;
			`OFS_IRQ_STATUS:  decode = link_ctrl_pkg::sel_irq_status;
			`OFS_IRQ_MASK:    decode = link_ctrl_pkg::sel_irq_mask;
			// Unmapped addresses select nothing
			default:          decode = link_ctrl_pkg::sel_none;
		endcase
	endfunction

	link_ctrl_pkg::reg_sel_t wr_sel;        // Write target
	link_ctrl_pkg::reg_sel_t rd_sel;        // Read target

	// Control fields
	logic                 mem_reset_n_q;    // Memory reset, active low
	logic                 sleep_req_q;      // Sleep request
	logic                 scr_bypass_q;     // Scrambler bypass
	logic                 limiter_off_q;    // Limiter switched off
	logic [`W_CREDIT-1:0] credit_q;         // Receive credit size
	logic [`W_MARKER-1:0] rx_thresh_q;      // Marker receive threshold
	logic [`W_MARKER-1:0] tx_count_q;       // Markers to send
	logic [`W_SLIP-1:0]   slip_q;           // Slip pulse interval
	logic [`W_CUBE-1:0]   cube_q;           // Lead cube identifier

	// Counters
	logic [31:0]          retry_tally_q;    // Link retries seen
	logic [31:0]          flip_tally_q;     // Forced bit flips seen
	logic                 tally_clear_q;    // Pending counter clear
	logic [`W_MARKER-1:0] marker_cnt_q;     // Received marker count
	logic [63:0]          rsp_tally_q;      // Good responses received

	// Interrupt state
	logic [`W_IRQ-1:0]    irq_event;        // Raw events this cycle
	logic [`W_IRQ-1:0]    irq_status_q;     // Sticky event bits
	logic [`W_IRQ-1:0]    irq_mask_q;       // Interrupt enables
	logic                 irq_rd_clear;     // Status read this cycle

	link_ctrl_pkg::word_t rd_data_q;        // Registered read data

	// Decode both strobes
	always_comb begin
		// No strobe, no selection
		wr_sel = wr_i ? decode(addr_i) : link_ctrl_pkg::sel_none;
		rd_sel = rd_i ? decode(addr_i) : link_ctrl_pkg::sel_none;
	end

	// Control register: four single-bit fields
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			// Memory released, test bits set
			mem_reset_n_q <= `RST_MEM_RESET;
			sleep_req_q   <= `RST_SLEEP_REQ;
			scr_bypass_q  <= `RST_SCR_BYPASS;
			limiter_off_q <= `RST_LIMITER_OFF;
		end else if (wr_sel == link_ctrl_pkg::sel_control) begin
			// Software write lands on this edge
			mem_reset_n_q <= wr_data_i[`BIT_MEM_RESET];
			sleep_req_q   <= wr_data_i[`BIT_SLEEP_REQ];
			scr_bypass_q  <= wr_data_i[`BIT_SCR_BYPASS];
			limiter_off_q <= wr_data_i[`BIT_LIMITER_OFF];
		end
	end

	// Receive credit size
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			// Build-time token count
			credit_q <= receive_credit_parameter;
		end else if (wr_sel == link_ctrl_pkg::sel_credit) begin
			// Upper write bits ignored
			credit_q <= wr_data_i[`W_CREDIT-1:0];
		end
	end

	// Retry marker configuration and cube identifier
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			// Marker counts and cube at defaults
			rx_thresh_q <= `RST_RX_THRESH;
			tx_count_q  <= `RST_TX_COUNT;
			cube_q      <= `RST_CUBE_ID;
		end else if (wr_sel == link_ctrl_pkg::sel_retry_cfg) begin
			// Five-bit marker fields
			rx_thresh_q <= wr_data_i[`POS_RX_THRESH +: `W_MARKER];
			tx_count_q  <= wr_data_i[`POS_TX_COUNT +: `W_MARKER];
			cube_q      <= wr_data_i[`POS_CUBE_ID +: `W_CUBE];
		end
	end

	// Bit slip pulse interval
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			// Default pacing
			slip_q <= `RST_SLIP;
		end else if (wr_sel == link_ctrl_pkg::sel_slip) begin
			// Upper write bits ignored
			slip_q <= wr_data_i[`W_SLIP-1:0];
		end
	end

	// Self-clearing counter clear field
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			tally_clear_q <= 1'h0;
		end else if (wr_sel == link_ctrl_pkg::sel_tally_clear) begin
			// Software arms the clear
			tally_clear_q <= wr_data_i[0];
		end else begin
			// Drops on the edge that clears
			tally_clear_q <= 1'h0;
		end
	end

	// Link retry counter
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			retry_tally_q <= 32'h0;
		end else if (tally_clear_q) begin
			// Clear beats a coincident event
			retry_tally_q <= 32'h0;
		end else if (retry_done_i) begin
			// One per retry, wraps at the top
			retry_tally_q <= retry_tally_q + 32'h1;
		end
	end

	// Forced bit flip counter
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			flip_tally_q <= 32'h0;
		end else if (tally_clear_q) begin
			// Clear beats a coincident event
			flip_tally_q <= 32'h0;
		end else if (bit_flip_i) begin
			// One per forced flip
			flip_tally_q <= flip_tally_q + 32'h1;
		end
	end

	// Received marker counter, saturates at 31
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			marker_cnt_q <= 5'h0;
		end else if (marker_rx_clear_i) begin
			// Link logic restarts the count
			marker_cnt_q <= 5'h0;
		end else if (marker_rx_i && (marker_cnt_q != 5'h1f)) begin
			// Holds at 31, never wraps
			marker_cnt_q <= marker_cnt_q + 5'h1;
		end
	end

	// Threshold reached: retry action may proceed
	always_comb begin
		// Level, follows count and threshold
		retry_action_o = (marker_cnt_q >= rx_thresh_q);
	end

	// Received response counter
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			// Count starts empty
			rsp_tally_q <= 64'h0;
		end else if (rsp_rcvd_i && !rsp_error_i) begin
			// Error responses are skipped
			rsp_tally_q <= rsp_tally_q + 64'h1;
		end
	end

	// Events that raise interrupt status
	always_comb begin
		irq_event               = '0;
		irq_event[`IRQ_RETRY]   = retry_done_i;
		irq_event[`IRQ_FLIP]    = bit_flip_i;
		// Marker that brings the count to threshold
		irq_event[`IRQ_THRESH]  = marker_rx_i &&
			((marker_cnt_q + 5'h1) == rx_thresh_q);
		// Error responses only
		irq_event[`IRQ_ERR_RSP] = rsp_rcvd_i && rsp_error_i;
		// A status read clears it
		irq_rd_clear = (rd_sel == link_ctrl_pkg::sel_irq_status);
	end

	// Sticky status bits; a new event beats the read clear
	generate
		for (genvar i = 0; i < `W_IRQ; i++) begin : g_irq
			always_ff @(posedge ref_clk_i) begin
				if (!nrst_i) begin
					irq_status_q[i] <= 1'h0;
				end else if (irq_event[i]) begin
					// Set wins
					irq_status_q[i] <= 1'h1;
				end else if (irq_rd_clear) begin
					// Cleared by reading
					irq_status_q[i] <= 1'h0;
				end
			end
		end
	endgenerate

	// Interrupt mask register
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			// All sources masked after reset
			irq_mask_q <= '0;
		end else if (wr_sel == link_ctrl_pkg::sel_irq_mask) begin
			irq_mask_q <= wr_data_i[`W_IRQ-1:0];
		end
	end

	// Level interrupt
	always_comb begin
		// High while an unmasked bit is set
		irq_o = |(irq_status_q & irq_mask_q);
	end

	// Read data, valid the cycle after the strobe only
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= '0;
			case (rd_sel)
				// Control bits at their positions
				link_ctrl_pkg::sel_control: begin
					rd_data_q[`BIT_MEM_RESET]   <= mem_reset_n_q;
					rd_data_q[`BIT_SLEEP_REQ]   <= sleep_req_q;
					rd_data_q[`BIT_SCR_BYPASS]  <= scr_bypass_q;
					rd_data_q[`BIT_LIMITER_OFF] <= limiter_off_q;
				end
				// Credit in the low bits
				link_ctrl_pkg::sel_credit: begin
					rd_data_q[`W_CREDIT-1:0] <= credit_q;
				end
				// Threshold, count and cube fields
				link_ctrl_pkg::sel_retry_cfg: begin
					rd_data_q[`POS_RX_THRESH +: `W_MARKER] <= rx_thresh_q;
					rd_data_q[`POS_TX_COUNT +: `W_MARKER]  <= tx_count_q;
					rd_data_q[`POS_CUBE_ID +: `W_CUBE]     <= cube_q;
				end
				// Pacing in the low byte
				link_ctrl_pkg::sel_slip: begin
					rd_data_q[`W_SLIP-1:0] <= slip_q;
				end
				// Live count, no snapshot
				link_ctrl_pkg::sel_retry_tally: begin
					rd_data_q <= retry_tally_q;
				end
				// Live count, no snapshot
				link_ctrl_pkg::sel_flip_tally: begin
					rd_data_q <= flip_tally_q;
				end
				// High only while a clear is pending
				link_ctrl_pkg::sel_tally_clear: begin
					rd_data_q[0] <= tally_clear_q;
				end
				link_ctrl_pkg::sel_status: begin
					// Sleep state as reported by link
					rd_data_q[`BIT_SLEEP_MODE] <= sleep_mode_i;
					rd_data_q[`POS_MARKER_CNT +: `W_MARKER] <= marker_cnt_q;
				end
				// Low half; read hi, lo, hi over a carry
				link_ctrl_pkg::sel_rsp_lo: begin
					rd_data_q <= rsp_tally_q[31:0];
				end
				// High half
				link_ctrl_pkg::sel_rsp_hi: begin
					rd_data_q <= rsp_tally_q[63:32];
				end
				// Value from before the read clear
				link_ctrl_pkg::sel_irq_status: begin
					rd_data_q[`W_IRQ-1:0] <= irq_status_q;
				end
				// Enables as written
				link_ctrl_pkg::sel_irq_mask: begin
					rd_data_q[`W_IRQ-1:0] <= irq_mask_q;
				end
				default: begin
					// Unmapped or no read: zero
					rd_data_q <= '0;
				end
			endcase
		end
	end

	// Outputs from flip-flops
	always_comb begin
		// Zero outside the cycle after a read
		rd_data_o                   = rd_data_q;
		mem_reset_n_o               = mem_reset_n_q;
		sleep_req_o                 = sleep_req_q;
		scramble_bypass_o           = scr_bypass_q;
		limiter_off_o               = limiter_off_q;
		receive_credit_size_o       = credit_q;
		retry_marker_rx_threshold_o = rx_thresh_q;
		retry_marker_tx_count_o     = tx_count_q;
		slip_pulse_interval_o       = slip_q;
		lead_cube_identifier_o      = cube_q;
	end

endmodule

// [tb/link_ctrl_sva.sv]
// Checker for the link control bank, bound to link_ctrl_regs.
// Assumes the defines header is on the include path and one clock domain.
`include "link_ctrl_defines.svh"
module link_ctrl_sva #(
	parameter logic [`W_CREDIT-1:0] receive_credit_parameter = `RST_CREDIT
) (
	input wire logic                 ref_clk_i,
	input wire logic                 nrst_i,
	input wire link_ctrl_pkg::addr_t addr_i,
	input wire link_ctrl_pkg::word_t wr_data_i,
	input wire logic                 wr_i,
	input wire logic                 rd_i,
	input wire link_ctrl_pkg::word_t rd_data_o,
	input wire logic                 retry_done_i,
	input wire logic                 bit_flip_i,
	input wire logic                 marker_rx_i,
	input wire logic                 marker_rx_clear_i,
	input wire logic                 rsp_error_i,
	input wire logic                 mem_reset_n_o,
	input wire logic                 sleep_req_o,
	input wire logic                 scramble_bypass_o,
	input wire logic                 limiter_off_o,
	input wire logic [`W_CREDIT-1:0] receive_credit_size_o,
	input wire logic [`W_MARKER-1:0] retry_marker_rx_threshold_o,
	input wire logic [`W_MARKER-1:0] retry_marker_tx_count_o,
	input wire logic [`W_SLIP-1:0]   slip_pulse_interval_o,
	input wire logic [`W_CUBE-1:0]   lead_cube_identifier_o,
	input wire logic                 retry_action_o,
	input wire logic                 irq_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	link_ctrl_pkg::word_t wd_q;  // Write data of the previous edge
	logic [31:0]          cnt_q; // Model of the retry tally
	logic                 clr_q; // Tally clear accepted last edge
	logic                 wc;    // Write to the control word
	logic                 ev_w;  // Anything that may raise the interrupt
	logic [3:0]           ctl;   // Control bits in register order
	assign wc = wr_i && addr_i == `OFS_CONTROL;
	assign ev_w = retry_done_i | bit_flip_i | marker_rx_i | rsp_error_i | wr_i;
	assign ctl = {limiter_off_o, scramble_bypass_o, sleep_req_o, mem_reset_n_o};
	// Keep last write data for field compares
	always_ff @(posedge ref_clk_i) wd_q <= wr_data_i;
	// Clear acts one edge after its write
	always_ff @(posedge ref_clk_i)
		clr_q <= nrst_i && wr_i && addr_i == `OFS_TALLY_CLEAR && wr_data_i[0];
	// Retry tally model, clear beats a same-edge event
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || clr_q)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 32'(retry_done_i);
	end
	reset_values_a:
		assert property (disable iff (1'b0) !nrst_i |=> ctl == 4'hf && !irq_o && rd_data_o == '0
			&& receive_credit_size_o == receive_credit_parameter
			&& retry_marker_rx_threshold_o == `RST_RX_THRESH && retry_marker_tx_count_o == `RST_TX_COUNT
			&& slip_pulse_interval_o == `RST_SLIP && lead_cube_identifier_o == `RST_CUBE_ID)
		else $error("fields not at reset values");
	ctrl_write_a:
		assert property (wc |=> ctl == wd_q[3:0]) else $error("control write not applied");
	ctrl_hold_a:
		assert property (!wc |=> $stable(ctl)) else $error("control changed without write");
	credit_write_a:
		assert property (wr_i && addr_i == `OFS_CREDIT |=> receive_credit_size_o == wd_q[9:0])
		else $error("credit write not applied");
	retry_cfg_write_a:
		assert property (wr_i && addr_i == `OFS_RETRY_CFG |=> retry_marker_rx_threshold_o == wd_q[4:0]
			&& retry_marker_tx_count_o == wd_q[12:8] && lead_cube_identifier_o == wd_q[18:16])
		else $error("retry config write not applied");
	slip_write_a:
		assert property (wr_i && addr_i == `OFS_SLIP |=> slip_pulse_interval_o == wd_q[7:0])
		else $error("slip write not applied");
	tally_read_a:
		assert property (rd_i && addr_i == `OFS_RETRY_TALLY |=> rd_data_o == $past(cnt_q))
		else $error("retry tally read wrong");
	rd_idle_a:
		assert property (!rd_i |=> rd_data_o == '0) else $error("read data without read");
	marker_clear_a:
		assert property (marker_rx_clear_i |=> !retry_action_o || retry_marker_rx_threshold_o == '0)
		else $error("retry action after marker clear");
	irq_cause_a:
		assert property ($rose(irq_o) |-> $past(ev_w)) else $error("interrupt without cause");
endmodule

// [tb/link_ctrl_regs_tb_top.sv]
// Self-checking bench for link_ctrl_regs, one task per scenario.
// Assumes the defines header on the include path; the bench drives all ports.
`include "link_ctrl_defines.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s expected %0h seen %0h", n, e, g); end end
module link_ctrl_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [`W_CREDIT-1:0] tb_credit = 10'h155; // Build credit under test
	logic ref_clk_i, nrst_i, wr_i, rd_i, sleep_mode_i;
	logic retry_done_i, bit_flip_i, marker_rx_i, marker_rx_clear_i, rsp_rcvd_i, rsp_error_i;
	logic [5:0]           evs;  // Event pulses, retry first
	link_ctrl_pkg::addr_t addr_i;
	link_ctrl_pkg::word_t wr_data_i, rd_data_o;
	logic mem_reset_n_o, sleep_req_o, scramble_bypass_o, limiter_off_o, retry_action_o, irq_o;
	logic [`W_CREDIT-1:0] receive_credit_size_o;
	logic [`W_MARKER-1:0] retry_marker_rx_threshold_o, retry_marker_tx_count_o;
	logic [`W_SLIP-1:0]   slip_pulse_interval_o;
	logic [`W_CUBE-1:0]   lead_cube_identifier_o;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [3:0]           ctl;  // Control outputs in register order
	logic [20:0]          fld;  // Marker, slip and cube outputs packed
	assign ctl = {limiter_off_o, scramble_bypass_o, sleep_req_o, mem_reset_n_o};
	assign fld = {retry_marker_tx_count_o, retry_marker_rx_threshold_o, slip_pulse_interval_o,
		lead_cube_identifier_o};
	assign {retry_done_i, bit_flip_i, marker_rx_i, marker_rx_clear_i, rsp_rcvd_i, rsp_error_i} = evs;
	link_ctrl_regs #(.receive_credit_parameter(tb_credit)) dut_u (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .retry_done_i(retry_done_i),
		.bit_flip_i(bit_flip_i), .marker_rx_i(marker_rx_i), .marker_rx_clear_i(marker_rx_clear_i),
		.rsp_rcvd_i(rsp_rcvd_i), .rsp_error_i(rsp_error_i), .sleep_mode_i(sleep_mode_i),
		.mem_reset_n_o(mem_reset_n_o), .sleep_req_o(sleep_req_o),
		.scramble_bypass_o(scramble_bypass_o), .limiter_off_o(limiter_off_o),
		.receive_credit_size_o(receive_credit_size_o),
		.retry_marker_rx_threshold_o(retry_marker_rx_threshold_o),
		.retry_marker_tx_count_o(retry_marker_tx_count_o),
		.slip_pulse_interval_o(slip_pulse_interval_o),
		.lead_cube_identifier_o(lead_cube_identifier_o), .retry_action_o(retry_action_o),
		.irq_o(irq_o));
	// Free-running 250 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	// Verdict and end of run
	task automatic final_report();
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One-cycle write strobe
	task automatic wr(input link_ctrl_pkg::addr_t a, input link_ctrl_pkg::word_t d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	// One-cycle read strobe, data judged in the following cycle
	task automatic rd(input link_ctrl_pkg::addr_t a, input link_ctrl_pkg::word_t e, input string n);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 `CHK(n, e, rd_data_o)
	endtask
	// Events held high for n back-to-back cycles
	task automatic ev(input logic [5:0] v, input int n);
		repeat (n) begin
			@(posedge ref_clk_i);
			evs <= v;
		end
		@(posedge ref_clk_i);
		evs <= '0;
	endtask
	// Reset for three edges, then control, credit, retry config, slip and tally defaults
	task automatic t_reset();
		nrst_i <= 1'b0;
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		#1 `CHK("ctrl_rst", 4'hf, ctl)
		rd(`OFS_CONTROL, 32'hf, "control");
		rd(`OFS_CREDIT, 32'(tb_credit), "credit");
		rd(`OFS_RETRY_CFG, 32'h1410, "retry_cfg");
		rd(`OFS_SLIP, 32'h30, "slip");
		rd(`OFS_RETRY_TALLY, 32'h0, "retry_tally");
		rd(`OFS_FLIP_TALLY, 32'h0, "flip_tally");
	endtask
	// Each control bit alone, wide fields at their top values
	task automatic t_ctrl();
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_CONTROL, 32'h1 << i);
			#1 `CHK("ctrl_bit", 4'h1 << i, ctl)
		end
		wr(`OFS_CREDIT, 32'h3ff);
		wr(`OFS_RETRY_CFG, 32'h71f1f);
		wr(`OFS_SLIP, 32'hff);
		wr(`OFS_RETRY_TALLY, 32'h5);
		#1 `CHK("fields", 21'h1fffff, fld)
		rd(`OFS_CREDIT, 32'h3ff, "credit_rw");
		rd(`OFS_RETRY_CFG, 32'h71f1f, "retry_cfg_rw");
		rd(`OFS_RETRY_TALLY, 32'h0, "tally_ro");
		rd(8'h40, 32'h0, "unmapped");
	endtask
	// Tallies count back-to-back events, then clear on a tally clear write
	task automatic t_tally();
		ev(6'h20, 3);
		ev(6'h10, 5);
		rd(`OFS_RETRY_TALLY, 32'h3, "retry_cnt");
		rd(`OFS_FLIP_TALLY, 32'h5, "flip_cnt");
		wr(`OFS_TALLY_CLEAR, 32'h1);
		rd(`OFS_RETRY_TALLY, 32'h0, "retry_clr");
		rd(`OFS_FLIP_TALLY, 32'h0, "flip_clr");
		rd(`OFS_TALLY_CLEAR, 32'h0, "clr_bit");
	endtask
	// Marker threshold, saturation at 31 and clear priority
	task automatic t_marker();
		wr(`OFS_RETRY_CFG, 32'h1403);
		ev(6'h08, 2);
		#1 `CHK("action_lo", 1'b0, retry_action_o)
		ev(6'h08, 1);
		#1 `CHK("action_hi", 1'b1, retry_action_o)
		ev(6'h08, 40);
		rd(`OFS_STATUS, 32'h1f00, "marker_sat");
		ev(6'h0c, 1);
		rd(`OFS_STATUS, 32'h0, "marker_clr");
	endtask
	// Error responses are not counted; sleep status follows the memory
	task automatic t_rsp();
		ev(6'h02, 4);
		ev(6'h03, 2);
		rd(`OFS_RSP_LO, 32'h4, "rsp_lo");
		rd(`OFS_RSP_HI, 32'h0, "rsp_hi");
		@(posedge ref_clk_i);
		sleep_mode_i <= 1'b1;
		rd(`OFS_STATUS, 32'h1, "sleep");
		@(posedge ref_clk_i);
		sleep_mode_i <= 1'b0;
	endtask
	// Sticky status, clear on read, mask gating
	task automatic t_irq();
		rd(`OFS_IRQ_STATUS, 32'hf, "irq_sticky");
		rd(`OFS_IRQ_STATUS, 32'h0, "irq_cleared");
		wr(`OFS_IRQ_MASK, 32'h1);
		ev(6'h10, 1);
		#1 `CHK("irq_masked", 1'b0, irq_o)
		ev(6'h20, 1);
		#1 `CHK("irq_on", 1'b1, irq_o)
		rd(`OFS_IRQ_STATUS, 32'h3, "irq_status");
		#1 `CHK("irq_off", 1'b0, irq_o)
	endtask
	// Hang guard
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			final_report();
		end
	end
	// Main sequence, second reset from a dirty state
	initial begin
		{nrst_i, wr_i, rd_i, sleep_mode_i, evs} = '0;
		addr_i = '0;
		wr_data_i = '0;
		t_reset();
		t_ctrl();
		t_tally();
		t_marker();
		t_rsp();
		t_irq();
		// Second reset starts on a clock edge
		@(posedge ref_clk_i);
		t_reset();
		final_report();
	end
endmodule
bind link_ctrl_regs link_ctrl_sva #(.receive_credit_parameter(receive_credit_parameter))
	chk_u (
	.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
	.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .retry_done_i(retry_done_i),
	.bit_flip_i(bit_flip_i), .marker_rx_i(marker_rx_i), .marker_rx_clear_i(marker_rx_clear_i),
	.rsp_error_i(rsp_error_i), .mem_reset_n_o(mem_reset_n_o), .sleep_req_o(sleep_req_o),
	.scramble_bypass_o(scramble_bypass_o), .limiter_off_o(limiter_off_o),
	.receive_credit_size_o(receive_credit_size_o),
	.retry_marker_rx_threshold_o(retry_marker_rx_threshold_o),
	.retry_marker_tx_count_o(retry_marker_tx_count_o),
	.slip_pulse_interval_o(slip_pulse_interval_o),
	.lead_cube_identifier_o(lead_cube_identifier_o), .retry_action_o(retry_action_o),
	.irq_o(irq_o));
